// [bsisp_regs.vh]
`ifndef BSISP_REGS_VH
`define BSISP_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BSISP_CTRL 8'h00
`define BSISP_STAT 8'h04
`define BSISP_SIG 8'h08
`define BSISP_CFG_SEL 2'h1

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define BSISP_CTRL_JTAG_EN 0
`define BSISP_CTRL_TMS_PU 1
`define BSISP_CTRL_TDI_PU 2
`define BSISP_CTRL_KEEP 3
`define BSISP_CTRL_RST 4'h1

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define BSISP_STAT_PROG 8
`define BSISP_STAT_LOCK 9
`define BSISP_STAT_FUSE 10

// ----------------------------------------------------------------------
// Test port pin positions
// ----------------------------------------------------------------------
`define BSISP_TCK 0
`define BSISP_TMS 1
`define BSISP_TDI 2
`define BSISP_TDO 3

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define BSISP_I_EXTEST 4'h0
`define BSISP_I_SAMPLE 4'h1
`define BSISP_I_IDCODE 4'h2
`define BSISP_I_HIGHZ 4'h3
`define BSISP_I_P_ENTER 4'h8
`define BSISP_I_P_WRITE 4'h9
`define BSISP_I_P_VERIFY 4'ha
`define BSISP_I_P_SIG 4'hb
`define BSISP_I_P_FUSE 4'hc
`define BSISP_I_P_EXIT 4'hd
`define BSISP_I_BYPASS 4'hf
`define BSISP_IR_CAPT 4'h1

// ----------------------------------------------------------------------
// Data register selection
// ----------------------------------------------------------------------
`define BSISP_DR_BYP 2'h0
`define BSISP_DR_BSR 2'h1
`define BSISP_DR_ID 2'h2
`define BSISP_DR_PRG 2'h3

`endif

// [bsisp_pin_cell.v]
`timescale 1ns/1ps
module bsisp_pin_cell (
  input wire pclk,
  input wire presetn,
  input wire capture,
  input wire shift,
  input wire update,
  input wire scan_in,
  input wire pin_val,
  input wire core_val,
  input wire core_en,
  output wire scan_out,
  output reg upd_val,
  output reg upd_en
);
  reg [2:0] cap;

  assign scan_out = cap[2];

  // ----------------------------------------------------------------------
  // Capture stages and update stages
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 3'h0;
      upd_val <= 1'b0;
      upd_en <= 1'b0;
    end else begin
      if (capture) begin
        cap <= {core_en, core_val, pin_val};
      end else if (shift) begin
        cap <= {cap[1:0], scan_in};
      end
      if (update) begin
        upd_val <= cap[1];
        upd_en <= cap[2];
      end
    end
  end
endmodule

// [bsisp_mc_cell.v]
`timescale 1ns/1ps
module bsisp_mc_cell (
  input wire pclk,
  input wire presetn,
  input wire capture,
  input wire shift,
  input wire update,
  input wire scan_in,
  input wire fb_val,
  input wire out_val,
  input wire out_en,
  output wire scan_out,
  output reg upd_val
);
  reg [2:0] cap;

  assign scan_out = cap[2];

  // ----------------------------------------------------------------------
  // Capture stages and single update stage
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= 3'h0;
      upd_val <= 1'b0;
    end else begin
      if (capture) begin
        cap <= {out_en, out_val, fb_val};
      end else if (shift) begin
        cap <= {cap[1:0], scan_in};
      end
      if (update) begin
        upd_val <= cap[0];
      end
    end
  end
endmodule

// [bsisp_port.v]
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bsisp_regs.vh"
module bsisp_port #(
  parameter N_IO = 32,
  parameter N_IN = 4,
  parameter N_MC = 32,
  parameter CFG_AW = 4,
  parameter [31:0] IDCODE_VAL = 32'h00000001 // Arbitrary value
) (
  input wire pclk,
  input wire presetn,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [N_IO-1:0] io_pin_in,
  output reg [N_IO-1:0] io_pin_out,
  output reg [N_IO-1:0] io_pin_oe,
  input wire [N_IN-1:0] in_pin_in,
  input wire [3:0] jtag_pin_in,
  output reg [3:0] jtag_pin_out,
  output reg [3:0] jtag_pin_oe,
  output reg [N_IO+N_IN-1:0] core_pin_in,
  input wire [N_IO-1:0] core_out,
  input wire [N_IO-1:0] core_oe,
  output reg [3:0] core_jtag_in,
  input wire [3:0] core_jtag_out,
  input wire [3:0] core_jtag_oe,
  input wire [N_MC-1:0] mc_fb,
  output wire [N_MC-1:0] mc_test,
  output reg tms_pullup_en,
  output reg tdi_pullup_en
);
  localparam NP = N_IO + N_IN;
  localparam NS = NP + 4;
  localparam NC = NP + N_MC;
  localparam TLR = 4'h0;
  localparam RTI = 4'h1;
  localparam SDS = 4'h2;
  localparam CDR = 4'h3;
  localparam SHDR = 4'h4;
  localparam E1DR = 4'h5;
  localparam PDR = 4'h6;
  localparam E2DR = 4'h7;
  localparam UDR = 4'h8;
  localparam SIS = 4'h9;
  localparam CIR = 4'ha;
  localparam SHIR = 4'hb;
  localparam E1IR = 4'hc;
  localparam PIR = 4'hd;
  localparam E2IR = 4'he;
  localparam UIR = 4'hf;

  function [1:0] dr_sel;
    input [3:0] ins;
    begin
      if (ins == `BSISP_I_EXTEST || ins == `BSISP_I_SAMPLE) begin
        dr_sel = `BSISP_DR_BSR;
      end else if (ins == `BSISP_I_IDCODE) begin
        dr_sel = `BSISP_DR_ID;
      end else if (ins == `BSISP_I_P_WRITE || ins == `BSISP_I_P_VERIFY ||
                   ins == `BSISP_I_P_SIG) begin
        dr_sel = `BSISP_DR_PRG;
      end else begin
        dr_sel = `BSISP_DR_BYP;
      end
    end
  endfunction

  reg [NS-1:0] pins_s1;
  reg [NS-1:0] pins_s2;
  reg tck_d;
  reg [3:0] ctrl;
  reg [3:0] tap;
  reg [3:0] next_tap;
  reg [3:0] ir;
  reg [3:0] ir_sr;
  reg bypass_sr;
  reg [31:0] id_sr;
  reg [31:0] prog_sr;
  reg [31:0] cfg [0:(1<<CFG_AW)-1];
  reg [CFG_AW-1:0] prog_addr;
  reg [15:0] user_sig;
  reg fuse;
  reg programming;
  reg locked;
  reg [N_IO-1:0] held;
  reg tdo;
  reg tdo_oe;
  reg [N_IO-1:0] next_io_out;
  reg [N_IO-1:0] next_io_oe;
  integer k;
  integer j;

  wire jtag_on = ctrl[`BSISP_CTRL_JTAG_EN];
  wire tck = pins_s2[NP+`BSISP_TCK];
  wire tms = pins_s2[NP+`BSISP_TMS];
  wire tdi = pins_s2[NP+`BSISP_TDI];
  wire tck_rise = jtag_on & tck & ~tck_d;
  wire tck_fall = jtag_on & ~tck & tck_d;
  wire [1:0] sel = dr_sel(ir);
  wire bsr_on = (sel == `BSISP_DR_BSR);
  wire cap_b = tck_rise & (tap == CDR) & bsr_on;
  wire shf_b = tck_rise & (tap == SHDR) & bsr_on;
  wire upd_b = tck_fall & (tap == UDR) & bsr_on;
  wire [NC:0] chain;
  wire [N_IO-1:0] bs_val;
  wire [N_IO-1:0] bs_en;
  wire ir_upd = tck_fall & (tap == UIR);
  wire dr_upd = tck_fall & (tap == UDR) & programming;
  wire bad_stop = programming & (~jtag_on | tap == TLR);
  wire apb_go = psel & penable & ~pready;

  assign chain[0] = tdi;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1 <= {NS{1'b0}};
      pins_s2 <= {NS{1'b0}};
      tck_d <= 1'b0;
      core_pin_in <= {NP{1'b0}};
      core_jtag_in <= 4'h0;
    end else begin
      pins_s1 <= {jtag_pin_in, in_pin_in, io_pin_in};
      pins_s2 <= pins_s1;
      tck_d <= tck;
      core_pin_in <= pins_s2[NP-1:0];
      core_jtag_in <= pins_s2[NS-1:NP];
    end
  end

  // ----------------------------------------------------------------------
  // Boundary cells
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : pin_cells
      if (g < N_IO) begin : io_c
        bsisp_pin_cell u_cell (
          .pclk(pclk), .presetn(presetn), .capture(cap_b), .shift(shf_b),
          .update(upd_b), .scan_in(chain[g]), .pin_val(pins_s2[g]),
          .core_val(core_out[g]), .core_en(core_oe[g]),
          .scan_out(chain[g+1]), .upd_val(bs_val[g]), .upd_en(bs_en[g])
        );
      end else begin : in_c
        bsisp_pin_cell u_cell (
          .pclk(pclk), .presetn(presetn), .capture(cap_b), .shift(shf_b),
          .update(upd_b), .scan_in(chain[g]), .pin_val(pins_s2[g]),
          .core_val(1'b0), .core_en(1'b0),
          .scan_out(chain[g+1]), .upd_val(), .upd_en()
        );
      end
    end
    for (g = 0; g < N_MC; g = g + 1) begin : mc_cells
      bsisp_mc_cell u_cell (
        .pclk(pclk), .presetn(presetn), .capture(cap_b), .shift(shf_b),
        .update(upd_b), .scan_in(chain[NP+g]), .fb_val(mc_fb[g]),
        .out_val(core_out[g % N_IO]), .out_en(core_oe[g % N_IO]),
        .scan_out(chain[NP+g+1]), .upd_val(mc_test[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // TAP state machine
  // ----------------------------------------------------------------------
  always @* begin
    case (tap)
      TLR: next_tap = tms ? TLR : RTI;
      RTI: next_tap = tms ? SDS : RTI;
      SDS: next_tap = tms ? SIS : CDR;
      CDR: next_tap = tms ? E1DR : SHDR;
      SHDR: next_tap = tms ? E1DR : SHDR;
      E1DR: next_tap = tms ? UDR : PDR;
      PDR: next_tap = tms ? E2DR : PDR;
      E2DR: next_tap = tms ? UDR : SHDR;
      UDR: next_tap = tms ? SDS : RTI;
      SIS: next_tap = tms ? TLR : CIR;
      CIR: next_tap = tms ? E1IR : SHIR;
      SHIR: next_tap = tms ? E1IR : SHIR;
      E1IR: next_tap = tms ? UIR : PIR;
      PIR: next_tap = tms ? E2IR : PIR;
      E2IR: next_tap = tms ? UIR : SHIR;
      default: next_tap = tms ? SDS : RTI;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap <= TLR;
    end else if (!jtag_on) begin
      tap <= TLR;
    end else if (tck_rise) begin
      tap <= next_tap;
    end
  end

  // ----------------------------------------------------------------------
  // Instruction and data shift registers
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir <= `BSISP_I_IDCODE;
      ir_sr <= 4'h0;
      bypass_sr <= 1'b0;
      id_sr <= 32'h0;
      prog_sr <= 32'h0;
    end else begin
      if (tap == TLR) begin
        ir <= `BSISP_I_IDCODE;
      end else if (ir_upd) begin
        ir <= ir_sr;
      end
      if (tck_rise && tap == CIR) begin
        ir_sr <= `BSISP_IR_CAPT;
      end else if (tck_rise && tap == SHIR) begin
        ir_sr <= {tdi, ir_sr[3:1]};
      end
      if (tck_rise && tap == CDR) begin
        bypass_sr <= 1'b0;
        id_sr <= IDCODE_VAL;
        if (ir == `BSISP_I_P_VERIFY) begin
          prog_sr <= fuse ? 32'h0 : cfg[prog_addr];
        end else if (ir == `BSISP_I_P_SIG) begin
          prog_sr <= {16'h0, user_sig};
        end else begin
          prog_sr <= 32'h0;
        end
      end else if (tck_rise && tap == SHDR) begin
        bypass_sr <= tdi;
        id_sr <= {tdi, id_sr[31:1]};
        prog_sr <= {tdi, prog_sr[31:1]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Test data output on falling TCK
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (!jtag_on) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (tap == SHDR) | (tap == SHIR);
      if (tap == SHIR) begin
        tdo <= ir_sr[0];
      end else if (sel == `BSISP_DR_BSR) begin
        tdo <= chain[NC];
      end else if (sel == `BSISP_DR_ID) begin
        tdo <= id_sr[0];
      end else if (sel == `BSISP_DR_PRG) begin
        tdo <= prog_sr[0];
      end else begin
        tdo <= bypass_sr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Programming sequence, fuse and lock
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      programming <= 1'b0;
      locked <= 1'b0;
      fuse <= 1'b0;
      prog_addr <= {CFG_AW{1'b0}};
      user_sig <= 16'h0;
      held <= {N_IO{1'b0}};
      for (k = 0; k < (1 << CFG_AW); k = k + 1) begin
        cfg[k] <= 32'h0;
      end
    end else begin
      if (bad_stop) begin
        programming <= 1'b0;
        locked <= 1'b1;
      end else if (ir_upd && ir_sr == `BSISP_I_P_ENTER) begin
        programming <= 1'b1;
        prog_addr <= {CFG_AW{1'b0}};
        held <= pins_s2[N_IO-1:0];
      end else if (ir_upd && ir_sr == `BSISP_I_P_EXIT && programming) begin
        programming <= 1'b0;
        locked <= 1'b0;
      end else if (ir_upd && ir_sr == `BSISP_I_P_FUSE && programming) begin
        fuse <= 1'b1;
      end else if (dr_upd) begin
        if (ir == `BSISP_I_P_WRITE) begin
          cfg[prog_addr] <= prog_sr;
          prog_addr <= prog_addr + {{(CFG_AW-1){1'b0}}, 1'b1};
        end else if (ir == `BSISP_I_P_VERIFY) begin
          prog_addr <= prog_addr + {{(CFG_AW-1){1'b0}}, 1'b1};
        end else if (ir == `BSISP_I_P_SIG) begin
          user_sig <= prog_sr[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive selection
  // ----------------------------------------------------------------------
  always @* begin
    for (j = 0; j < N_IO; j = j + 1) begin
      if (locked) begin
        next_io_out[j] = 1'b0;
        next_io_oe[j] = 1'b0;
      end else if (programming) begin
        next_io_out[j] = held[j];
        next_io_oe[j] = ctrl[`BSISP_CTRL_KEEP];
      end else if (jtag_on && ir == `BSISP_I_HIGHZ) begin
        next_io_out[j] = 1'b0;
        next_io_oe[j] = 1'b0;
      end else if (jtag_on && ir == `BSISP_I_EXTEST) begin
        next_io_out[j] = bs_val[j];
        next_io_oe[j] = bs_en[j];
      end else begin
        next_io_out[j] = core_out[j];
        next_io_oe[j] = core_oe[j];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pin_out <= {N_IO{1'b0}};
      io_pin_oe <= {N_IO{1'b0}};
      jtag_pin_out <= 4'h0;
      jtag_pin_oe <= 4'h0;
      tms_pullup_en <= 1'b0;
      tdi_pullup_en <= 1'b0;
    end else begin
      io_pin_out <= next_io_out;
      io_pin_oe <= next_io_oe;
      if (jtag_on) begin
        jtag_pin_out <= {tdo, 3'h0};
        jtag_pin_oe <= {tdo_oe & ~locked, 3'h0};
      end else begin
        jtag_pin_out <= core_jtag_out;
        jtag_pin_oe <= locked ? 4'h0 : core_jtag_oe;
      end
      tms_pullup_en <= jtag_on & ctrl[`BSISP_CTRL_TMS_PU];
      tdi_pullup_en <= jtag_on & ctrl[`BSISP_CTRL_TDI_PU];
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `BSISP_CTRL_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (apb_go) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (paddr == `BSISP_CTRL) begin
        if (pwrite) begin
          ctrl <= pwdata[3:0];
        end else begin
          prdata <= {28'h0, ctrl};
        end
      end else if (paddr == `BSISP_STAT) begin
        if (!pwrite) begin
          prdata <= {21'h0, fuse, locked, programming, ir, tap};
        end
      end else if (paddr == `BSISP_SIG) begin
        if (!pwrite) begin
          prdata <= {16'h0, user_sig};
        end
      end else if (paddr[7:6] == `BSISP_CFG_SEL && paddr[1:0] == 2'h0 &&
                   paddr[5:2] < (1 << CFG_AW)) begin
        if (!pwrite) begin
          prdata <= fuse ? 32'h0 : cfg[paddr[CFG_AW+1:2]];
        end
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// [bsisp_port_props.sv]
`timescale 1ns/1ps
module bsisp_port_props #(
  parameter N_IO = 32,
  parameter N_IN = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [N_IO-1:0] io_pin_in,
  input wire logic [N_IN-1:0] in_pin_in,
  input wire logic [N_IO+N_IN-1:0] core_pin_in,
  input wire logic [3:0] jtag_pin_in,
  input wire logic [3:0] jtag_pin_out,
  input wire logic [3:0] jtag_pin_oe,
  input wire logic tms_pullup_en,
  input wire logic tdi_pullup_en
);
  // ----------------
  // Helper logic
  // ----------------
  reg [2:0] up;
  wire acc = psel && penable && !pready;
  wire wr_ctrl = psel && penable && pwrite && paddr == 8'h00;
  wire map = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08 ||
    (paddr[7:6] == 2'h1 && paddr[1:0] == 2'h0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up <= 3'h0;
    end else if (up != 3'h4) begin
      up <= up + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // Properties
  // ----------------
  ready_one_wait_a: assert property (
    acc && !$past(acc) |=> pready ##1 !pready)
    else $error("pready not one wait state");
  ready_cause_a: assert property (pready |-> $past(acc))
    else $error("pready without access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (
    acc && !map && paddr[1:0] == 2'h0 |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && map |=> !pslverr)
    else $error("mapped access refused");
  tms_pullup_a: assert property ($changed(tms_pullup_en) |->
    $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("tms pull-up changed without write");
  tdi_pullup_a: assert property ($changed(tdi_pullup_en) |->
    $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("tdi pull-up changed without write");
  core_in_lat_a: assert property (up == 3'h4 |->
    core_pin_in == $past({in_pin_in, io_pin_in}, 3))
    else $error("core pin copy latency wrong");
  tdo_hold_a: assert property (
    jtag_pin_oe == 4'h8 && $past(jtag_pin_oe) == 4'h8 && jtag_pin_in[0] &&
    $past(jtag_pin_in[0]) && $past(jtag_pin_in[0], 2) &&
    $past(jtag_pin_in[0], 3) |-> $stable(jtag_pin_out[3]))
    else $error("tdo moved while tck high");
endmodule
bind bsisp_port bsisp_port_props #(.N_IO(N_IO), .N_IN(N_IN)) u_props (
  .pclk(pclk),
  .presetn(presetn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .io_pin_in(io_pin_in),
  .in_pin_in(in_pin_in),
  .core_pin_in(core_pin_in),
  .jtag_pin_in(jtag_pin_in),
  .jtag_pin_out(jtag_pin_out),
  .jtag_pin_oe(jtag_pin_oe),
  .tms_pullup_en(tms_pullup_en),
  .tdi_pullup_en(tdi_pullup_en)
);

// [bsisp_prog.sv]
`timescale 1ns/1ps
module bsisp_prog (
  input wire pclk,
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo
);
  // ----------------
  // Test port driver
  // ----------------
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // TMS and TDI change with TCK low, TDO read while TCK high
  task tick(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge pclk);
    tck <= 1'b1;
    repeat (2) @(posedge pclk);
    o = tdo;
    repeat (2) @(posedge pclk);
    tck <= 1'b0;
  endtask
  task tlr();
    logic o;
    repeat (5) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
  // From idle: capture, shift n bits LSB first, update, back to idle
  task scan(input logic ir, input logic [255:0] din, input int n,
    output logic [255:0] dout);
    logic o;
    int i;
    dout = '0;
    tick(1'b1, 1'b0, o);
    if (ir) begin
      tick(1'b1, 1'b0, o);
    end
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
  endtask
endmodule

// [bsisp_port_tb.sv]
`timescale 1ns/1ps
`include "bsisp_regs.vh"
module bsisp_port_tb;
  localparam [31:0] ID = 32'h0000_0a53; // Arbitrary value
  localparam [31:0] EX_OUT = 32'h3c5a_96f0;
  localparam [31:0] EX_OE = 32'hff00_f0f0;
  localparam [31:0] MC_PAT = 32'h0f0f_3355;
  localparam [31:0] W0 = 32'h1357_9bdf;
  localparam [31:0] W1 = 32'h2468_ace0;
  reg pclk = 0;
  reg presetn = 0;
  reg [7:0] paddr = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [31:0] pwdata = 0;
  reg [31:0] ext = 0, core_out = 0, core_oe = 0, mc_fb = 0;
  reg [3:0] in_pin = 0, cj_out = 0, cj_oe = 0;
  reg tdo_last = 0;
  reg [31:0] q;
  reg e;
  reg [255:0] dout, pre, exp, msk;
  wire [31:0] prdata, io_pin_out, io_pin_oe, io_pin_in, mc_test, lvl;
  wire [3:0] jtag_pin_out, jtag_pin_oe, cj_in;
  wire [35:0] core_pin_in;
  wire pready, pslverr, tms_pu, tdi_pu, tck, tms, tdi;
  wire tdo_w = jtag_pin_oe[3] ? jtag_pin_out[3] : ~tdo_last;
  integer miscompares = 0, num_checks = 0, i;
  assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & ext);
  assign lvl = (core_oe & core_out) | (~core_oe & ext);
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (jtag_pin_oe[3]) tdo_last <= jtag_pin_out[3];
  bsisp_port #(.IDCODE_VAL(ID)) u_bsisp_port (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .io_pin_in(io_pin_in),
    .io_pin_out(io_pin_out),
    .io_pin_oe(io_pin_oe),
    .in_pin_in(in_pin),
    .jtag_pin_in({tdo_w, tdi, tms, tck}),
    .jtag_pin_out(jtag_pin_out),
    .jtag_pin_oe(jtag_pin_oe),
    .core_pin_in(core_pin_in),
    .core_out(core_out),
    .core_oe(core_oe),
    .core_jtag_in(cj_in),
    .core_jtag_out(cj_out),
    .core_jtag_oe(cj_oe),
    .mc_fb(mc_fb),
    .mc_test(mc_test),
    .tms_pullup_en(tms_pu),
    .tdi_pullup_en(tdi_pu)
  );
  bsisp_prog u_bsisp_prog (
    .pclk(pclk),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo_w)
  );
  // ----------------
  // Shared tasks
  // ----------------
  task chk(input string nm, input logic [255:0] ex, input logic [255:0] g);
    num_checks++;
    if (g !== ex) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task ir(input logic [3:0] c);
    u_bsisp_prog.scan(1'b1, c, 4, dout);
  endtask
  task dr(input logic [255:0] d, input int n);
    u_bsisp_prog.scan(1'b0, d, n, dout);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_regs();
    apb(0, `BSISP_CTRL, 0);
    chk("ctrl reset", 32'h1, q);
    apb(0, `BSISP_STAT, 0);
    chk("stat reset", 7'h02, q[10:4]);
    apb(1, 8'h10, 0);
    chk("unmapped err", 1'b1, e);
    apb(1, `BSISP_CTRL, 32'h7);
    repeat (3) @(posedge pclk);
    chk("pullups on", 2'b11, {tms_pu, tdi_pu});
    apb(1, `BSISP_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("pullups off", 2'b00, {tms_pu, tdi_pu});
  endtask
  task t_id();
    u_bsisp_prog.tlr();
    dr(0, 32);
    chk("idcode", ID, dout[31:0]);
    ir(`BSISP_I_BYPASS);
    chk("ir capture", `BSISP_IR_CAPT, dout[3:0]);
    dr(8'ha5, 8);
    chk("bypass", 8'h4a, dout[7:0]);
  endtask
  task t_bsr();
    core_oe <= 32'h0000_ffff;
    core_out <= 32'h1234_abcd;
    ext <= 32'hc3a5_5a3c;
    in_pin <= 4'ha;
    mc_fb <= 32'h6699_a5c3;
    repeat (4) @(posedge pclk);
    pre = '0;
    exp = '0;
    msk = {204{1'b1}};
    for (i = 0; i < 32; i++) begin
      pre[(67-i)*3+1] = EX_OUT[i];
      pre[(67-i)*3] = EX_OE[i];
      pre[(31-i)*3+2] = MC_PAT[i];
      exp[(67-i)*3+2] = lvl[i];
      exp[(67-i)*3+1] = core_out[i];
      exp[(67-i)*3] = core_oe[i];
      exp[(31-i)*3+2] = mc_fb[i];
      exp[(31-i)*3+1] = core_out[i];
      exp[(31-i)*3] = core_oe[i];
    end
    for (i = 0; i < 4; i++) begin
      exp[(35-i)*3+2] = in_pin[i];
      msk[(35-i)*3+1] = 1'b0;
      msk[(35-i)*3] = 1'b0;
    end
    ir(`BSISP_I_SAMPLE);
    dr(pre, 204);
    chk("sample chain", exp & msk, dout & msk);
    chk("macro update", MC_PAT, mc_test);
    ir(`BSISP_I_EXTEST);
    repeat (4) @(posedge pclk);
    chk("extest out", EX_OUT, io_pin_out);
    chk("extest oe", EX_OE, io_pin_oe);
    ir(`BSISP_I_HIGHZ);
    repeat (4) @(posedge pclk);
    chk("highz oe", 32'h0, io_pin_oe);
  endtask
  task t_prog();
    u_bsisp_prog.tlr();
    apb(1, `BSISP_CTRL, 32'h9);
    core_oe <= 32'h0;
    ext <= 32'h5a5a_0ff0;
    repeat (4) @(posedge pclk);
    ir(`BSISP_I_P_ENTER);
    repeat (4) @(posedge pclk);
    chk("keeper oe", 32'hffff_ffff, io_pin_oe);
    chk("keeper level", 32'h5a5a_0ff0, io_pin_out);
    ir(`BSISP_I_P_WRITE);
    dr(W0, 32);
    dr(W1, 32);
    ir(`BSISP_I_P_SIG);
    dr(16'hbeef, 32);
    apb(0, 8'h44, 0);
    chk("config word", W1, q);
    ir(`BSISP_I_P_ENTER);
    ir(`BSISP_I_P_VERIFY);
    dr(0, 32);
    chk("verify open", W0, dout[31:0]);
    ir(`BSISP_I_P_FUSE);
    ir(`BSISP_I_P_ENTER);
    ir(`BSISP_I_P_VERIFY);
    dr(0, 32);
    chk("verify fused", 32'h0, dout[31:0]);
    apb(0, 8'h40, 0);
    chk("config fused", 32'h0, q);
    ir(`BSISP_I_P_SIG);
    dr(16'hbeef, 32);
    chk("sig scan", 16'hbeef, dout[15:0]);
    apb(0, `BSISP_SIG, 0);
    chk("sig reg", 16'hbeef, q[15:0]);
    ir(`BSISP_I_P_EXIT);
    apb(0, `BSISP_STAT, 0);
    chk("stat fused", 3'b100, q[10:8]);
  endtask
  task t_lock();
    apb(1, `BSISP_CTRL, 32'h1);
    ir(`BSISP_I_P_ENTER);
    repeat (4) @(posedge pclk);
    chk("prog highz", 32'h0, io_pin_oe);
    u_bsisp_prog.tlr();
    core_oe <= 32'hffff_ffff;
    apb(0, `BSISP_STAT, 0);
    chk("locked", 2'b10, q[9:8]);
    chk("lock io oe", 32'h0, io_pin_oe);
    cj_oe <= 4'hf;
    apb(1, `BSISP_CTRL, 32'h0);
    chk("lock jtag oe", 4'h0, jtag_pin_oe);
    apb(1, `BSISP_CTRL, 32'h1);
    u_bsisp_prog.tlr();
    ir(`BSISP_I_P_ENTER);
    ir(`BSISP_I_P_EXIT);
    apb(0, `BSISP_STAT, 0);
    chk("unlocked", 2'b00, q[9:8]);
    chk("io oe back", 32'hffff_ffff, io_pin_oe);
  endtask
  task t_off();
    cj_out <= 4'h5;
    cj_oe <= 4'h6;
    apb(1, `BSISP_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("user pin oe", 4'h6, jtag_pin_oe);
    chk("user pin out", 4'h5, jtag_pin_out);
    chk("user pin in", {tdo_w, tdi, tms, tck}, cj_in);
    do_reset();
    apb(0, `BSISP_STAT, 0);
    chk("fuse cleared", 7'h02, q[10:4]);
  endtask
  initial begin
    #3000000;
    miscompares++;
    final_report();
  end
  initial begin
    do_reset();
    t_regs();
    t_id();
    t_bsr();
    t_prog();
    t_lock();
    t_off();
    final_report();
  end
endmodule
